// *** bench/clockgen_config_control_assertions.sv ***
`default_nettype none

module clockgen_config_control_assertions
	import clockgen_pkg::*;
(
	input wire logic                     ref_clk,              // Core clock
	input wire logic                     rst,                  // Sync reset
	input wire logic                     i2c_scl,              // Bus clock
	input wire logic                     i2c_sda_in,           // Bus data
	input wire logic                     i2c_sda_out,          // Data value
	input wire logic                     i2c_sda_oe,           // Data pull
	input wire logic [2:0]               config_select_pins,   // Config pins
	input wire logic                     source_select_pin,    // Ref pin
	input wire logic                     shutdown_enable_pin,  // Shutdown pin
	input wire logic                     crystal_ref_lost,     // Crystal dead
	input wire logic                     alternate_clock_lost, // Alt dead
	input wire clockgen_pkg::clock_sel_t clock_sel,            // Ref control
	input wire clockgen_pkg::out_ctrl_t  clock_output,         // Outputs
	input wire logic [2:0]               config_index,         // Config
	input wire logic                     eeprom_busy           // Busy
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	busy_in_reset_a: assert property (disable iff (1'b0)
		rst |=> eeprom_busy && config_index == 3'h0)
		else $error("busy or config wrong after reset");
	no_ack_busy_a: assert property (eeprom_busy |-> !i2c_sda_oe)
		else $error("data pulled while busy");
	cfg_range_a: assert property (config_index <= LAST_CONFIG)
		else $error("config index out of range");
	cfg_follow_a: assert property (($stable(config_select_pins)
		&& config_select_pins <= LAST_CONFIG && !eeprom_busy)[*8]
		|-> config_index == config_select_pins)
		else $error("config index does not follow pins");
	shutdown_all_a: assert property (clock_sel.pll_shutdown[*3]
		|-> clock_output.drive_en == '1 && clock_output.running == '0)
		else $error("outputs not suspended in shutdown");
	// Pin passes two sync stages and a register before shutdown shows
	shut_pin_a: assert property ($rose(clock_sel.pll_shutdown)
		|-> $past(shutdown_enable_pin, 3))
		else $error("shutdown without pin high");
	running_sub_a: assert property
		((clock_output.running & ~clock_output.drive_en) == '0)
		else $error("running output not driven");
	ack_hold_a: assert property ($rose(i2c_sda_oe)
		|-> i2c_sda_oe[*8])
		else $error("data pull too short");
	busy_len_a: assert property ($rose(eeprom_busy)
		|-> eeprom_busy[*8])
		else $error("busy pulse too short");

	cover property ($rose(eeprom_busy));
	cover property (clock_sel.pll_shutdown);
	cover property ($rose(i2c_sda_oe));
	cover property ($fell(clock_sel.use_crystal));
endmodule : clockgen_config_control_assertions

bind clockgen_config_control clockgen_config_control_assertions chk (
	.ref_clk, .rst, .i2c_scl, .i2c_sda_in, .i2c_sda_out, .i2c_sda_oe,
	.config_select_pins, .source_select_pin, .shutdown_enable_pin,
	.crystal_ref_lost, .alternate_clock_lost, .clock_sel, .clock_output,
	.config_index, .eeprom_busy
);

`default_nettype wire

// *** bench/clockgen_config_control_tb_top.sv ***
`default_nettype none

`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
	failures++; $display("mismatch %s expected %h seen %h", nm, e, g); end end

module clockgen_config_control_tb_top;
	import clockgen_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	logic       ref_clk = 1'b0;
	logic       rst = 1'b1;
	logic [2:0] cfg = 3'h0;
	logic       src = 1'b0;
	logic       sdp = 1'b0;
	logic       xlost = 1'b0;
	logic       alost = 1'b0;
	logic       m_scl;
	logic       m_oe;
	logic       sda_line;
	logic       sda_out;
	logic       sda_oe;
	logic       busy;
	logic [2:0] cidx;
	clock_sel_t csel;
	out_ctrl_t  outs;
	int         failures = 0;
	int         num_checks = 0;

	always #10 ref_clk = !ref_clk;
	// Pull-up: either party pulling low wins
	assign sda_line = (sda_oe ? sda_out : 1'b1) & !m_oe;

	clockgen_config_control dut (
		.ref_clk(ref_clk), .rst(rst), .i2c_scl(m_scl), .i2c_sda_in(sda_line),
		.i2c_sda_out(sda_out), .i2c_sda_oe(sda_oe),
		.config_select_pins(cfg), .source_select_pin(src),
		.shutdown_enable_pin(sdp), .crystal_ref_lost(xlost),
		.alternate_clock_lost(alost), .clock_sel(csel), .clock_output(outs),
		.config_index(cidx), .eeprom_busy(busy)
	);

	i2c_master_model m (
		.clk(ref_clk), .sda(sda_line), .scl(m_scl), .sda_oe(m_oe)
	);

	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : close_out

	task automatic step(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : step

	task automatic wb(input logic [7:0] b, input logic acked);
		logic [7:0] rx;
		logic       ak;
		m.xfer(b, 1'b1, rx, ak);
		`CHK("ack", acked, !ak)
	endtask : wb

	task automatic rb(input logic [7:0] exp, input logic last);
		logic [7:0] rx;
		logic       ak;
		m.xfer(8'hff, last, rx, ak);
		`CHK("rdata", exp, rx)
	endtask : rb

	task automatic wr1(input logic [7:0] a, input logic [7:0] d);
		m.start();
		wb(8'hd4, 1);
		wb(8'h00, 1);
		wb(a, 1);
		wb(d, 1);
		m.stop();
		step(12);
	endtask : wr1

	task automatic wait_idle();
		for (int n = 0; n < 3000 && busy !== 1'b0; n++)
			step(1);
		`CHK("busy", 1'b0, busy)
	endtask : wait_idle

	initial begin
		#1900000;
		failures++;
		close_out();
	end

	initial begin
		step(5);
		rst = 1'b0;
		`CHK("busy", 1'b1, busy)
		m.start();
		wb(8'hd4, 0);
		m.stop();
		wait_idle();
		m.start();
		wb(8'hd4, 1);
		wb(8'h00, 1);
		wb(8'h10, 1);
		wb(8'h3f, 1);
		wb(8'h0f, 1);
		m.stop();
		wr1(8'h18, 8'h30);
		`CHK("outs", {6'h3f, 6'h3f}, outs)
		sdp = 1'b1;
		step(12);
		`CHK("outs", {6'h3f, 6'h0f}, outs)
		cfg = 3'h1;
		step(12);
		`CHK("outs", {6'h0f, 6'h0f}, outs)
		cfg = 3'h5;
		step(12);
		`CHK("cfg", 3'h5, cidx)
		`CHK("outs", {6'h00, 6'h00}, outs)
		cfg = 3'h0;
		wr1(8'h02, 8'h01);
		`CHK("outs", {6'h3f, 6'h3f}, outs)
		wr1(8'h02, 8'h03);
		`CHK("outs", {6'h3f, 6'h00}, outs)
		`CHK("pll", 1'b1, csel.pll_shutdown)
		sdp = 1'b0;
		step(12);
		`CHK("outs", {6'h3f, 6'h0f}, outs)
		wr1(8'h02, 8'h0c);
		for (int p = 0; p < 2; p++) begin
			src = p[0];
			step(12);
			`CHK("csel", {1'b1, p[0], 3'h0}, csel)
		end
		src = 1'b0;
		wr1(8'h02, 8'h20);
		xlost = 1'b1;
		step(12);
		`CHK("alt", 1'b0, csel.use_crystal)
		xlost = 1'b0;
		step(12);
		`CHK("sticky", 1'b0, csel.use_crystal)
		wr1(8'h02, 8'h30);
		`CHK("revert", {1'b0, 1'b1, 2'h3, 1'b0}, csel)
		wr1(8'h02, 8'h38);
		alost = 1'b1;
		step(12);
		`CHK("alt lost", 1'b1, csel.use_crystal)
		alost = 1'b0;
		step(12);
		`CHK("alt back", 1'b0, csel.use_crystal)
		m.start();
		wb(8'hd4, 1);
		wb(8'h03, 1);
		wb(8'h10, 1);
		wb(8'h00, 1);
		m.stop();
		m.start();
		wb(8'hd4, 1);
		wb(8'h01, 1);
		m.stop();
		step(8);
		`CHK("busy", 1'b1, busy)
		m.start();
		wb(8'hd4, 0);
		m.stop();
		wait_idle();
		wr1(8'h10, 8'h00);
		m.start();
		wb(8'hd4, 1);
		wb(8'h02, 1);
		m.stop();
		wait_idle();
		m.start();
		wb(8'hd4, 1);
		wb(8'h00, 1);
		wb(8'h10, 1);
		m.start();
		wb(8'hd5, 1);
		rb(DEVICE_ID_BYTE, 0);
		rb(8'h3f, 0);
		rb(8'h0f, 1);
		m.stop();
		close_out();
	end
endmodule : clockgen_config_control_tb_top

`default_nettype wire

// *** bench/i2c_master_model.sv ***
`default_nettype none

module i2c_master_model (
	input  wire logic clk,    // Pacing clock
	input  wire logic sda,    // Resolved data line
	output var  logic scl,    // Bus clock, idles high
	output var  logic sda_oe  // High pulls data low
);
	timeunit 1ns;
	timeprecision 1ps;
	// Phases above 1.3 us; the slave samples too slowly for faster SCL
	localparam int HALF = 66;

	initial begin
		scl = 1'b1;
		sda_oe = 1'b0;
	end

	task automatic tk(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tk

	// Data moves a few cycles after the fall so no false START is seen
	task automatic bit_io(input logic b, output logic s);
		sda_oe = !b;
		tk(HALF);
		scl = 1'b1;
		tk(HALF);
		s = sda;
		scl = 1'b0;
		tk(4);
	endtask : bit_io

	task automatic start();
		sda_oe = 1'b0;
		tk(HALF);
		scl = 1'b1;
		tk(HALF);
		sda_oe = 1'b1;
		tk(HALF);
		scl = 1'b0;
		tk(4);
	endtask : start

	task automatic stop();
		sda_oe = 1'b1;
		tk(HALF);
		scl = 1'b1;
		tk(HALF);
		sda_oe = 1'b0;
		tk(HALF);
	endtask : stop

	task automatic xfer(input logic [7:0] tx, input logic ack_in,
		output logic [7:0] rx, output logic ack);
		for (int i = 7; i >= 0; i--)
			bit_io(tx[i], rx[i]);
		bit_io(ack_in, ack);
	endtask : xfer
endmodule : i2c_master_model

`default_nettype wire

// *** hw/clockgen_config_control.sv ***
// Behaviour
// [R1] Config pins zero to five pick stored configuration
// [R2] Controller never drives config pins six or seven
// [R3] Bus register writes accepted anytime, effective immediately
// [R4] Bypass bit lets external clock drive crystal input
// [R5] Primary bit swaps primary and secondary sources
// [R6] Source pin low primary, high secondary
// [R7] Switchover mode: manual, auto one-way, auto-revertive
// [R8] Polarity bit in register two, default zero
// [R9] Shutdown bit: global shutdown versus output enable
// [R10] Output select, gating and pin set output state
// [R11] Shutdown bit with pin high suspends everything
// [R12] Answer fixed seven-bit slave address, write and read
// [R13] Command low bits: write, save, restore
// [R14] Register address byte, then data bytes until STOP
// [R15] Pointer advances after every byte written or read
// [R16] Master sets read address with write frame first
// [R17] Read returns identity byte then data, master NACKs last
// [R18] Save or restore after STOP, no acks meanwhile
// [R19] Other masters treat bus busy during save/restore
// [R20] Restore at power-up, acknowledge only when ready
// [R21] Command code three ignored without any action
`default_nettype none

module clockgen_config_control
	import clockgen_pkg::*;
(
	input  wire logic       ref_clk,              // Core clock, 50 MHz
	input  wire logic       rst,                  // Synchronous, high
	input  wire logic       i2c_scl,              // Bus clock from master
	input  wire logic       i2c_sda_in,           // Bus data level
	output var  logic       i2c_sda_out,          // Bus data drive value
	output var  logic       i2c_sda_oe,           // High pulls data low
	input  wire logic [2:0] config_select_pins,   // Stored config choice
	input  wire logic       source_select_pin,    // Reference choice
	input  wire logic       shutdown_enable_pin,  // Shutdown/enable pin
	input  wire logic       crystal_ref_lost,     // Crystal input dead
	input  wire logic       alternate_clock_lost, // Alternate input dead
	output var  clockgen_pkg::clock_sel_t clock_sel,   // Reference control
	output var  clockgen_pkg::out_ctrl_t  clock_output, // Output states
	output var  logic [2:0] config_index,         // Applied configuration
	output var  logic       eeprom_busy           // Save/restore running
);
	import clockgen_pkg::*;

	typedef struct packed {
		state_t                   st;
		op_t                      op;
		wstep_t                   wstep;
		pins_t                    sync1;
		pins_t                    sync2;
		pins_t                    prev;
		logic [7:0]               shreg;
		logic [3:0]               bitcnt;
		logic                     ackph;
		logic                     addr_phase;
		logic                     tx;
		logic                     ack_ok;
		logic [7:0]               ptr;
		logic [7:0]               eidx;
		logic [7:0]               wait_cnt;
		logic [4:0]               hold;
		logic                     sda_oe;
		logic                     sda_out;
		logic                     on_secondary;
		logic [2:0]               cfg_idx;
		logic                     busy;
		clock_sel_t               clk_sel;
		out_ctrl_t                outs;
		logic [NUM_REGS-1:0][7:0] regs;
		logic [NUM_REGS-1:0][7:0] ee;
	} ctl_t;

	ctl_t s;
	ctl_t next_s;

	logic                   cap_value;
	logic                   cap_toggle;
	pins_t                  pins_now;
	logic [7:0]             global_reg;
	logic [7:0]             sel_byte;
	logic [7:0]             gate_byte;
	logic                   global_sd;
	logic                   suspend_level;
	logic [NUM_OUTPUTS-1:0] drive_calc;
	logic [NUM_OUTPUTS-1:0] run_calc;

	// Bits are sampled on the bus clock; the toggle crosses over and the
	// sampled value is stable for far longer than the crossing takes.
	scl_bit_capture u_capture (
		.i2c_scl    (i2c_scl),
		.i2c_sda_in (i2c_sda_in),
		.bit_value  (cap_value),
		.bit_toggle (cap_toggle)
	);

	always_comb begin
		pins_now.scl             = i2c_scl;
		pins_now.sda             = i2c_sda_in;
		pins_now.config_select   = config_select_pins;
		pins_now.source_select   = source_select_pin;
		pins_now.shutdown_enable = shutdown_enable_pin;
		pins_now.crystal_lost    = crystal_ref_lost;
		pins_now.alternate_lost  = alternate_clock_lost;
		pins_now.bit_toggle      = cap_toggle;
	end

	assign global_reg    = s.regs[REG_GLOBAL];
	assign sel_byte      = s.regs[OUT_SEL_BASE + {5'h00, s.cfg_idx}];
	assign gate_byte     = s.regs[OUT_GATE_BASE + {5'h00, s.cfg_idx}];
	assign global_sd     = global_reg[SHUTDOWN_BIT]
		& s.sync2.shutdown_enable;                            // [R9] [R11]
	// Pin level that suspends a gated output follows the polarity bit
	assign suspend_level = s.sync2.shutdown_enable
		^ global_reg[POLARITY_BIT];                           // [R8]

	// Disabled-level mode has no say: a deselected output is high-Z except in global shutdown, which drives every output.
	for (genvar i = 0; i < NUM_OUTPUTS; i++) begin : g_out
		assign drive_calc[i] = sel_byte[i] | global_sd;       // [R10] [R11]
		assign run_calc[i]   = sel_byte[i] & ~global_sd
			& ~(gate_byte[i] & suspend_level);                // [R10]
	end

	always_comb begin
		logic       rise;
		logic       scl_fell;
		logic       fall;
		logic       start_c;
		logic       stop_c;
		logic       primary_lost;
		logic       reading;
		logic [7:0] byte_in;
		logic [7:0] byte_out;

		next_s       = s;
		rise         = s.sync2.bit_toggle != s.prev.bit_toggle;
		scl_fell     = s.prev.scl & ~s.sync2.scl;
		start_c      = s.prev.scl & s.sync2.scl & s.prev.sda & ~s.sync2.sda;
		stop_c       = s.prev.scl & s.sync2.scl & ~s.prev.sda & s.sync2.sda;
		fall         = s.hold == 5'h01;
		reading      = s.tx & ~s.addr_phase;
		byte_in      = {s.shreg[6:0], cap_value};
		byte_out     = s.addr_phase ? DEVICE_ID_BYTE : s.regs[s.ptr]; // [R17]
		primary_lost = global_reg[PRIMARY_BIT] ? s.sync2.alternate_lost
			: s.sync2.crystal_lost;

		// Pins pass two stages before any decision is taken on them
		next_s.sync1   = pins_now;
		next_s.sync2   = s.sync1;
		next_s.prev    = s.sync2;
		next_s.sda_out = 1'b0;

		// Data changes wait out a hold time after the clock falls
		if (scl_fell) begin
			next_s.hold = SDA_HOLD_CYCLES;
		end else if (s.hold != 5'h00) begin
			next_s.hold = s.hold - 5'h01;
		end

		case (s.st)
			ST_BOOT, ST_BUSY: begin
				// One byte per step; the bus is deaf meanwhile
				// Restore copies storage into registers, save the reverse
				if (s.wait_cnt != 8'h00) begin
					next_s.wait_cnt = s.wait_cnt - 8'h01;
				end else begin
					if (s.op == OP_SAVE) begin
						next_s.ee[s.eidx] = s.regs[s.eidx];   // [R13]
					end else begin
						next_s.regs[s.eidx] = s.ee[s.eidx];   // [R13] [R20]
					end
					next_s.eidx     = s.eidx + 8'h01;
					next_s.wait_cnt = EE_BYTE_CYCLES - 8'h01;
					if (s.eidx == LAST_REG) begin
						next_s.st = ST_IDLE;                  // [R18] [R20]
						next_s.op = OP_NONE;
					end
				end
			end
			ST_XFER: begin
				if (rise) begin
					if (s.ackph) begin
						// Master NACK ends the read; bus left alone
						if (reading && cap_value) begin
							next_s.st = ST_SKIP;              // [R17]
						end
					end else if (reading) begin
						next_s.shreg  = {s.shreg[6:0], 1'b0};
						next_s.bitcnt = s.bitcnt + 4'h1;
					end else begin
						next_s.shreg  = byte_in;
						next_s.bitcnt = s.bitcnt + 4'h1;
						if (s.bitcnt == 4'h7) begin
							next_s.ack_ok = 1'b1;
							if (s.addr_phase) begin
								if (byte_in[7:1] != I2C_SLAVE_ADDR) begin
									next_s.st     = ST_SKIP;      // [R12]
									next_s.ack_ok = 1'b0;
								end
								next_s.tx = byte_in[0];           // [R12]
							end else begin
								case (s.wstep)
									W_CMD: begin
										case (byte_in[1:0])           // [R13]
											CMD_WRITE: begin
												next_s.wstep = W_ADDR;
											end
											CMD_SAVE: begin
												next_s.op    = OP_SAVE;
												next_s.wstep = W_IGNORE;
											end
											CMD_LOAD: begin
												next_s.op    = OP_LOAD;
												next_s.wstep = W_IGNORE;
											end
											default: begin
												next_s.wstep = W_IGNORE; // [R21]
											end
										endcase
									end
									W_ADDR: begin
										next_s.ptr   = byte_in;       // [R14]
										next_s.wstep = W_DATA;
									end
									W_DATA: begin
										next_s.regs[s.ptr] = byte_in; // [R3] [R14]
										next_s.ptr = s.ptr + 8'h01;   // [R15]
									end
									default: begin
									end
								endcase
							end
						end
					end
				end
				if (fall) begin
					if (s.ackph) begin
						next_s.ackph      = 1'b0;
						next_s.bitcnt     = 4'h0;
						next_s.addr_phase = 1'b0;
						if (s.tx) begin
							next_s.shreg  = byte_out;
							next_s.sda_oe = ~byte_out[7];
							if (!s.addr_phase) begin
								next_s.ptr = s.ptr + 8'h01;       // [R15]
							end
						end else begin
							next_s.sda_oe = 1'b0;
						end
					end else if (s.bitcnt == 4'h8) begin
						next_s.ackph  = 1'b1;
						next_s.sda_oe = reading ? 1'b0 : s.ack_ok;
					end else if (reading) begin
						next_s.sda_oe = ~s.shreg[7];
					end
				end
			end
			default: begin
			end
		endcase

		// Bus conditions are heard only while no save or restore runs
		if (s.st != ST_BOOT && s.st != ST_BUSY) begin           // [R18]
			if (start_c) begin
				next_s.st         = ST_XFER;
				next_s.bitcnt     = 4'h0;
				next_s.ackph      = 1'b0;
				next_s.addr_phase = 1'b1;
				next_s.tx         = 1'b0;
				next_s.ack_ok     = 1'b0;
				next_s.sda_oe     = 1'b0;
				next_s.wstep      = W_CMD;
			end else if (stop_c) begin
				next_s.sda_oe = 1'b0;
				if (s.op != OP_NONE) begin
					next_s.st       = ST_BUSY;                      // [R18]
					next_s.eidx     = 8'h00;
					next_s.wait_cnt = EE_BYTE_CYCLES - 8'h01;
				end else begin
					next_s.st = ST_IDLE;
				end
			end
		end
		next_s.busy = next_s.st == ST_BOOT || next_s.st == ST_BUSY;

		// Reserved codes keep the last valid configuration
		if (s.sync2.config_select <= LAST_CONFIG) begin           // [R1] [R2]
			next_s.cfg_idx = s.sync2.config_select;
		end

		// Manual follows the pin; auto modes watch the primary input
		case (global_reg[MODE_LSB +: 2])                          // [R7]
			MODE_AUTO: begin
				// One-way: once on the secondary, stays there
				if (primary_lost) begin
					next_s.on_secondary = 1'b1;
				end
			end
			MODE_REVERT: begin
				next_s.on_secondary = primary_lost;
			end
			default: begin
				next_s.on_secondary = s.sync2.source_select;     // [R6]
			end
		endcase

		// Registered so downstream logic never sees decode glitches
		next_s.clk_sel.crystal_bypass  = global_reg[BYPASS_BIT]; // [R4]
		next_s.clk_sel.use_crystal     = ~(s.on_secondary
			^ global_reg[PRIMARY_BIT]);                          // [R5] [R6]
		next_s.clk_sel.switchover_mode = global_reg[MODE_LSB +: 2];
		next_s.clk_sel.pll_shutdown    = global_sd;              // [R11]
		next_s.outs.drive_en           = drive_calc;             // [R10]
		next_s.outs.running            = run_calc;               // [R10]
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			// Power-up: blank storage, then an automatic restore
			s          <= '0;
			s.st       <= ST_BOOT;                                // [R20]
			s.op       <= OP_LOAD;
			s.wstep    <= W_CMD;
			s.busy     <= 1'b1;
			s.wait_cnt <= EE_BYTE_CYCLES - 8'h01;
			s.cfg_idx  <= CONFIG_RESET;
			s.regs     <= {NUM_REGS{REG_RESET}};
			s.ee       <= {NUM_REGS{REG_RESET}};
		end else begin
			s <= next_s;
		end
	end

	assign i2c_sda_out  = s.sda_out;
	assign i2c_sda_oe   = s.sda_oe;
	assign clock_sel    = s.clk_sel;
	assign clock_output = s.outs;
	assign config_index = s.cfg_idx;
	assign eeprom_busy  = s.busy;

endmodule : clockgen_config_control

`default_nettype wire

// *** hw/scl_bit_capture.sv ***
`default_nettype none

module scl_bit_capture (
	input  wire logic i2c_scl,     // Bus clock, link domain
	input  wire logic i2c_sda_in,  // Bus data level
	output var  logic bit_value,   // Last bit sampled on a rising edge
	output var  logic bit_toggle   // Flips once per sampled bit
);
	import clockgen_pkg::*;

	// The bus clock stands still between frames, so no reset can reach
	// this domain; a power-up value keeps the toggle parity defined.
	capture_t s = '0;
	capture_t next_s;

	always_comb begin
		next_s        = s;
		next_s.value  = i2c_sda_in;
		next_s.toggle = ~s.toggle;
	end

	always_ff @(posedge i2c_scl) begin
		s <= next_s;
	end

	assign bit_value  = s.value;
	assign bit_toggle = s.toggle;

endmodule : scl_bit_capture

`default_nettype wire

// *** pkg/clockgen_pkg.sv ***
`default_nettype none

package clockgen_pkg;

	// Bus identity and command decode
	localparam logic [6:0] I2C_SLAVE_ADDR = 7'h6a;
	// Arbitrary identity value returned ahead of read data
	localparam logic [7:0] DEVICE_ID_BYTE = 8'h5a;
	localparam logic [1:0] CMD_WRITE      = 2'h0;
	localparam logic [1:0] CMD_SAVE       = 2'h1;
	localparam logic [1:0] CMD_LOAD       = 2'h2;

	// Register map
	localparam int         NUM_REGS       = 256;
	localparam int         NUM_OUTPUTS    = 6;
	localparam logic [2:0] LAST_CONFIG    = 3'h5;
	localparam logic [7:0] REG_GLOBAL     = 8'h02;
	localparam logic [7:0] OUT_SEL_BASE   = 8'h10;
	localparam logic [7:0] OUT_GATE_BASE  = 8'h18;
	localparam logic [7:0] LAST_REG       = 8'hff;

	// Field positions inside the global register
	localparam int         POLARITY_BIT   = 0;
	localparam int         SHUTDOWN_BIT   = 1;
	localparam int         BYPASS_BIT     = 2;
	localparam int         PRIMARY_BIT    = 3;
	localparam int         MODE_LSB       = 4;

	// Switchover mode codes; a clear upper bit means manual
	localparam logic [1:0] MODE_AUTO      = 2'h2;
	localparam logic [1:0] MODE_REVERT    = 2'h3;

	// Reset values
	localparam logic [7:0] REG_RESET      = 8'h00;
	localparam logic [2:0] CONFIG_RESET   = 3'h0;

	// Timing
	localparam int         REF_CLK_PERIOD_NS = 20;
	localparam int         EE_BYTE_NS        = 100;
	localparam int         SDA_HOLD_NS       = 300;
	localparam logic [7:0] EE_BYTE_CYCLES    = 8'((EE_BYTE_NS
		+ REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS);
	localparam logic [4:0] SDA_HOLD_CYCLES   = 5'((SDA_HOLD_NS
		+ REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS);

	typedef enum logic [2:0] {
		ST_BOOT,
		ST_IDLE,
		ST_XFER,
		ST_SKIP,
		ST_BUSY
	} state_t;

	typedef enum logic [1:0] {
		OP_NONE,
		OP_SAVE,
		OP_LOAD
	} op_t;

	typedef enum logic [1:0] {
		W_CMD,
		W_ADDR,
		W_DATA,
		W_IGNORE
	} wstep_t;

	typedef struct packed {
		logic       scl;
		logic       sda;
		logic [2:0] config_select;
		logic       source_select;
		logic       shutdown_enable;
		logic       crystal_lost;
		logic       alternate_lost;
		logic       bit_toggle;
	} pins_t;

	typedef struct packed {
		logic       crystal_bypass;
		logic       use_crystal;
		logic [1:0] switchover_mode;
		logic       pll_shutdown;
	} clock_sel_t;

	typedef struct packed {
		logic [NUM_OUTPUTS-1:0] drive_en;
		logic [NUM_OUTPUTS-1:0] running;
	} out_ctrl_t;

	typedef struct packed {
		logic value;
		logic toggle;
	} capture_t;

endpackage : clockgen_pkg

`default_nettype wire
